// *** logic/ee2w_slave.sv ***
// Purpose: two-wire serial slave front end of a byte-wide nonvolatile memory
// Assumes: bus lines pass through two flip-flops; serial clock also clocks a data latch
// Notes:   page writes buffered, committed after a self-timed delay
//
// Contract
// - main array holds 8192 bytes
// - extra 32-byte page, lockable read-only
// - works at 100k, 400k and 1M bus rates
// - input bits sampled at serial clock rise
// - output bit changes only at clock fall
// - data line open drain, never driven high
// - address pins must match received address bits
// - write protect high rejects all writes
// - write protect low allows writes normally
// - undriven write protect counts as low
// - page writes up to 32 bytes, partial allowed
// - programming self-timed, done within 5 ms
// - random and sequential reads supported
// - MSB first, ninth clock carries acknowledge
// - detect start and stop with clock high
// - address byte: type, pins, direction bit
// - acknowledge match unless programming, otherwise no acknowledge, standby
`timescale 1ns/1ps
module ee2w_slave
#(
  parameter int T_WR = ee2w_pkg::T_WR_CYC
)
(
  input  wire logic mclk_i,
  input  wire logic srst_i,
  input  wire logic scl_clk_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  input  wire logic wp_i,
  input  wire logic hw_addr_pin_0_i,
  input  wire logic hw_addr_pin_1_i,
  input  wire logic hw_addr_pin_2_i,
  output logic      busy_o
);
  import ee2w_pkg::*;

  ee2w_state_t r;
  ee2w_state_t next_r;
  logic        lk_bit;
  logic        rise;
  logic        fall;
  logic        start;
  logic        stop;
  logic        type_ok;
  logic        push;
  logic        wr_rdy;
  ee2w_wb_t    push_wb;
  ee2w_wb_t    pop_wb;
  logic        pop_valid;
  logic        pop_ready;
  logic [7:0]  rdata;
  logic [7:0]  mem [MEM_WORDS];
  logic [7:0]  idmem [PAGE_BYTES];
  // link domain: data latched on the serial clock rise, read in the system
  // domain only after the synchronised rise, when it has long settled
  always_ff @(posedge scl_clk_i)
  begin
    lk_bit <= sda_i;
  end
  // edges on the twice-registered levels; 5 ns sampling leaves wide margin
  // even at the fastest bus rate
  assign rise  = r.scl2 && !r.sclq;
  assign fall  = !r.scl2 && r.sclq;
  assign start = r.scl2 && r.sclq && !r.sda2 && r.sdaq;
  assign stop  = r.scl2 && r.sclq && r.sda2 && !r.sdaq;
  assign type_ok = (r.sh[7:4] == DEV_TYPE) || (r.sh[7:4] == ID_TYPE);
  assign rdata   = r.idsel ? idmem[r.addr[4:0]] : mem[r.addr];
  assign push_wb = '{col: r.col, data: r.sh};
  // drain stalls while programming; the page image must not move under it
  assign pop_ready = !r.busy;
  // pin only ever pulled low
  assign sda_o    = 1'b0;
  assign sda_oe_o = r.oe;
  assign busy_o   = r.busy;
  ee2w_fifo
  #(
    .W ($bits(ee2w_wb_t)),
    .D (FIFO_DEPTH)
  )
  u_fifo
  (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (push),
    .in_ready_o  (wr_rdy),
    .in_data_i   (push_wb),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_wb)
  );
  always_comb
  begin
    next_r        = r;
    push          = 1'b0;
    next_r.scl1   = scl_clk_i;
    next_r.scl2   = r.scl1;
    next_r.sclq   = r.scl2;
    next_r.sda1   = sda_i;
    next_r.sda2   = r.sda1;
    next_r.sdaq   = r.sda2;
    // a floating protect pin reads low through the pad pull-down
    next_r.wp1    = wp_i;
    next_r.wp2    = r.wp1;
    next_r.a1     = {hw_addr_pin_2_i, hw_addr_pin_1_i, hw_addr_pin_0_i};
    next_r.a2     = r.a1;
    next_r.commit = 1'b0;
    if (start)
    begin
      next_r.st     = ST_RX;
      next_r.bitcnt = '0;
      next_r.phase  = PH_DEV;
      next_r.oe     = 1'b0;
    end
    else if (stop)
    begin
      next_r.st    = ST_IDLE;
      next_r.oe    = 1'b0;
      next_r.wrote = 1'b0;
      if (r.wrote && !r.busy)
      begin
        if (!r.wp2 && !(r.wid && r.lock))
        begin
          next_r.busy = 1'b1;
          next_r.wcnt = '0;
        end
        else
        begin
          next_r.pmask = '0;
        end
      end
    end
    else
    begin
      case (r.st)
        ST_IDLE:
        begin
          next_r.oe = 1'b0;
        end
        ST_RX:
        begin
          if (rise)
          begin
            next_r.sh     = {r.sh[6:0], lk_bit};
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
          if (fall && r.bitcnt == BIT_ACK)
          begin
            next_r.bitcnt = '0;
            next_r.st     = ST_ACK;
            case (r.phase)
              PH_DEV:
              begin
                if (type_ok && r.sh[3:1] == r.a2 && !r.busy)
                begin
                  next_r.oe    = 1'b1;
                  next_r.phase = PH_AHI;
                  next_r.rd    = r.sh[0];
                  next_r.idsel = (r.sh[7:4] == ID_TYPE);
                end
                else
                begin
                  next_r.st = ST_IDLE;
                end
              end
              PH_AHI:
              begin
                next_r.oe         = 1'b1;
                next_r.phase      = PH_ALO;
                next_r.addr[12:8] = r.sh[4:0];
              end
              PH_ALO:
              begin
                next_r.oe        = 1'b1;
                next_r.phase     = PH_DATA;
                next_r.addr[7:0] = r.sh;
                next_r.col       = r.sh[4:0];
                next_r.wpage     = {r.addr[12:8], r.sh[7:5]};
                next_r.wid       = r.idsel;
                next_r.pmask     = '0;
                next_r.lockreq   = 1'b0;
              end
              default:
              begin
                // a full buffer answers with no acknowledge
                if (!r.rd && wr_rdy)
                begin
                  next_r.oe    = 1'b1;
                  push         = 1'b1;
                  next_r.wrote = 1'b1;
                  next_r.col   = r.col + 5'h1;
                  if (r.idsel && r.addr[LOCK_BIT])
                  begin
                    next_r.lockreq = 1'b1;
                  end
                end
              end
            endcase
          end
        end
        ST_ACK:
        begin
          if (fall)
          begin
            if (r.rd)
            begin
              next_r.st     = ST_TX;
              next_r.sh     = rdata;
              next_r.oe     = !rdata[7];
              next_r.bitcnt = '0;
            end
            else
            begin
              next_r.st = ST_RX;
              next_r.oe = 1'b0;
            end
          end
        end
        ST_TX:
        begin
          if (rise)
          begin
            next_r.bitcnt = r.bitcnt + 4'h1;
          end
          if (fall)
          begin
            if (r.bitcnt == BIT_ACK)
            begin
              next_r.oe = 1'b0;
              next_r.st = ST_MACK;
            end
            else
            begin
              next_r.sh = {r.sh[6:0], 1'b0};
              next_r.oe = !r.sh[6];
            end
          end
        end
        ST_MACK:
        begin
          if (rise)
          begin
            if (!lk_bit)
            begin
              next_r.addr = r.addr + 13'h1;
              next_r.st   = ST_ACK;
            end
            else
            begin
              next_r.st = ST_IDLE;
            end
          end
        end
        default:
        begin
          next_r.st = ST_IDLE;
        end
      endcase
    end
    if (pop_valid && pop_ready)
    begin
      next_r.pbuf[pop_wb.col]  = pop_wb.data;
      next_r.pmask[pop_wb.col] = 1'b1;
    end
    if (r.busy)
    begin
      next_r.wcnt = r.wcnt + 1'b1;
      if (r.wcnt == WCNT_W'(T_WR - 1))
      begin
        next_r.busy   = 1'b0;
        next_r.commit = 1'b1;
        if (r.lockreq)
        begin
          next_r.lock = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      r <= '{st: ST_IDLE, scl1: 1'b1, scl2: 1'b1, sclq: 1'b1, sda1: 1'b1, sda2: 1'b1,
             sdaq: 1'b1, default: '0};  // idle bus level: no false edge after reset
    end
    else
    begin
      r <= next_r;
    end
  end
  // array commit: all marked bytes of one page land together; a lock request commits none of them
  always_ff @(posedge mclk_i)
  begin
    if (r.commit && !r.lockreq)
    begin
      for (int i = 0; i < PAGE_BYTES; i++)
      begin
        if (r.pmask[i])
        begin
          if (r.wid)
          begin
            idmem[i] <= r.pbuf[i];
          end
          else
          begin
            mem[{r.wpage, i[4:0]}] <= r.pbuf[i];
          end
        end
      end
    end
  end

  a_oe_on_fall:
    assert property (@(posedge mclk_i) disable iff (srst_i) $rose(r.oe) |-> $past(fall))
      else $error("data line pulled low away from a clock fall");
  a_bit_on_rise:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      $changed(r.bitcnt) && r.bitcnt != 4'h0 |-> $past(rise))
      else $error("bit counted without a clock rise");
  a_start_rx:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      start |=> r.st == ST_RX && r.bitcnt == 4'h0 && !r.oe)
      else $error("start not taken");
  a_stop_idle:
    assert property (@(posedge mclk_i) disable iff (srst_i) stop |=> r.st == ST_IDLE && !r.oe)
      else $error("stop did not return to standby");
  a_addr_match:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      $rose(r.oe) && r.st == ST_ACK && r.phase == PH_AHI |-> r.sh[3:1] == r.a2 && type_ok)
      else $error("address acknowledged without a match");
  a_busy_nack:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      r.busy |-> !(r.st == ST_ACK && r.oe && r.phase == PH_AHI))
      else $error("address acknowledged while programming");
  a_wp_block:
    assert property (@(posedge mclk_i) disable iff (srst_i) $rose(r.busy) |-> !$past(r.wp2))
      else $error("programming started under write protect");
  a_wr_time:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      $fell(r.busy) |-> r.commit && $past(r.wcnt) == WCNT_W'(T_WR - 1))
      else $error("programming time wrong");
  a_seq_next:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      r.st == ST_MACK && rise && !lk_bit |=> r.addr == $past(r.addr) + 13'h1 ##1 r.st == ST_ACK)
      else $error("sequential read did not advance");
  a_ack_release:
    assert property (@(posedge mclk_i) disable iff (srst_i)
      r.st == ST_ACK && fall && !r.rd |=> !r.oe)
      else $error("acknowledge not released after ninth clock");
  a_lock_ro:
    assert property (@(posedge mclk_i) disable iff (srst_i) $rose(r.busy) |-> !(r.wid && r.lock))
      else $error("write to locked page accepted");

  c_seq_read: cover property (@(posedge mclk_i) disable iff (srst_i)
    r.st == ST_MACK && rise && !lk_bit);
  c_commit: cover property (@(posedge mclk_i) disable iff (srst_i) r.commit && r.pmask != '0);
  c_busy_poll: cover property (@(posedge mclk_i) disable iff (srst_i)
    r.busy && fall && r.st == ST_RX && r.bitcnt == BIT_ACK && r.phase == PH_DEV);
  c_lock: cover property (@(posedge mclk_i) disable iff (srst_i) $rose(r.lock));

endmodule

// *** logic/ee2w_pkg.sv ***
// Purpose: shared constants and types of the two-wire memory slave
// Assumes: system clock of 200 MHz; serial clock arrives as its own clock
// Notes:   memory contents are not reset, being nonvolatile in intent
package ee2w_pkg;

  localparam int          CLK_MHZ    = 200;
  localparam int          T_WR_MS    = 5;
  localparam int          T_WR_CYC   = T_WR_MS * CLK_MHZ * 1000;
  localparam int          WCNT_W     = 20;
  localparam int          MEM_WORDS  = 8192;
  localparam int          ADDR_W     = 13;
  localparam int          PAGE_BYTES = 32;
  localparam int          FIFO_DEPTH = 4;
  localparam int          LOCK_BIT   = 10;
  localparam logic [3:0]  DEV_TYPE   = 4'hA;  // arbitrary type code
  localparam logic [3:0]  ID_TYPE    = 4'hB;  // arbitrary type code
  localparam logic [3:0]  BIT_ACK    = 4'h8;
  localparam logic [1:0]  PH_DEV     = 2'h0;
  localparam logic [1:0]  PH_AHI     = 2'h1;
  localparam logic [1:0]  PH_ALO     = 2'h2;
  localparam logic [1:0]  PH_DATA    = 2'h3;

  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_MACK = 5'h10
  } ee2w_st_t;

  typedef struct packed
  {
    logic [4:0] col;
    logic [7:0] data;
  } ee2w_wb_t;

  typedef struct packed
  {
    logic                       scl1, scl2, sclq, sda1, sda2, sdaq, wp1, wp2;
    logic [2:0]                 a1, a2;
    ee2w_st_t                   st;
    logic [3:0]                 bitcnt;
    logic [1:0]                 phase;
    logic [7:0]                 sh;
    logic                       rd, idsel, oe, wrote, lockreq, busy, commit, wid, lock;
    logic [ADDR_W-1:0]          addr;
    logic [4:0]                 col;
    logic [7:0]                 wpage;
    logic [WCNT_W-1:0]          wcnt;
    logic [PAGE_BYTES-1:0]      pmask;
    logic [PAGE_BYTES-1:0][7:0] pbuf;
  } ee2w_state_t;

endpackage

// *** logic/ee2w_fifo.sv ***
// Purpose: small first-in first-out buffer with valid/ready on both sides
// Assumes: depth is a power of two
// Notes:   full and empty told apart by an extra pointer bit
`timescale 1ns/1ps
module ee2w_fifo
#(
  parameter int W = 13,
  parameter int D = ee2w_pkg::FIFO_DEPTH
)
(
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  import ee2w_pkg::*;

  localparam int AW = $clog2(D);

  typedef struct packed
  {
    logic [D-1:0][W-1:0] mem;
    logic [AW:0]         wptr;
    logic [AW:0]         rptr;
  } ee2w_fq_t;

  ee2w_fq_t r;
  ee2w_fq_t next_r;
  logic     full;
  logic     empty;

  assign full        = (r.wptr[AW] != r.rptr[AW]) && (r.wptr[AW-1:0] == r.rptr[AW-1:0]);
  assign empty       = (r.wptr == r.rptr);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = r.mem[r.rptr[AW-1:0]];

  always_comb
  begin
    next_r = r;
    if (in_valid_i && !full)
    begin
      next_r.mem[r.wptr[AW-1:0]] = in_data_i;
      next_r.wptr                = r.wptr + 1'b1;
    end
    if (out_ready_i && !empty)
    begin
      next_r.rptr = r.rptr + 1'b1;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

endmodule

// *** dv/ee2w_master.sv ***
// Purpose: behavioural two-wire bus master facing the memory slave
// Assumes: wire resolved outside; a released data line reads high because the master drives it to 1
// Notes:   bit time 80 ns; lo_ext stretches the low phase for slow runs
`timescale 1ns/1ps
module ee2w_master
(
  output logic      scl_o,
  output logic      sda_drv_o,
  input  wire logic sda_i
);
  int lo_ext;

  initial
  begin
    scl_o     = 1'b1;
    sda_drv_o = 1'b1;
    lo_ext    = 0;
  end

  // data moves mid low phase, clear of the slave's answer delay of at most 15 ns
  task automatic bit_x(input logic b, output logic r);
    sda_drv_o = b;
    #(24 + lo_ext);
    scl_o = 1'b1;
    r = sda_i;
    #32;
    scl_o = 1'b0;
    #24;
  endtask

  task automatic start();
    sda_drv_o = 1'b1;
    #24;
    scl_o = 1'b1;
    #24;
    sda_drv_o = 1'b0;
    #24;
    scl_o = 1'b0;
    #24;
  endtask

  task automatic stop();
    sda_drv_o = 1'b0;
    #24;
    scl_o = 1'b1;
    #24;
    sda_drv_o = 1'b1;
    #24;
  endtask

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(b[i], r);
    bit_x(1'b1, ack);
  endtask

  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, b[i]);
    bit_x(nack, r);
  endtask
endmodule

// *** dv/testbench.sv ***
// Purpose: self-checking bench of the two-wire memory slave
// Assumes: bus master model drives clock and data wires
// Notes:   programming time cut to TW cycles so polls fit inside it
`timescale 1ns/1ps
module testbench;
  import ee2w_pkg::*;
  localparam int TW = 400;
  logic       mclk;
  logic       srst;
  logic       wp;
  logic [2:0] pins;
  logic       scl;
  logic       sda_drv;
  logic       sda_o;
  logic       sda_oe;
  logic       busy;
  wire        sda;
  int         error_cnt;
  int         total_checks;
  int         bcyc;
  int         blen;
  logic       ack;
  logic [7:0] rb;

  // a slave driving high here would corrupt acks and read data
  assign sda = sda_oe ? sda_o : sda_drv;

  ee2w_slave #(.T_WR(TW)) ee2w_slave_i (.mclk_i(mclk), .srst_i(srst), .scl_clk_i(scl),
    .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe), .wp_i(wp), .hw_addr_pin_0_i(pins[0]),
    .hw_addr_pin_1_i(pins[1]), .hw_addr_pin_2_i(pins[2]), .busy_o(busy));
  ee2w_master ee2w_master_i (.scl_o(scl), .sda_drv_o(sda_drv), .sda_i(sda));

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // busy length counted from its own rise; prog may start before or after it
  always @(negedge mclk)
  begin
    bcyc <= (busy === 1'b1) ? bcyc + 1 : 0;
    if (busy !== 1'b1 && bcyc != 0)
      blen <= bcyc;
  end

  function automatic logic ne(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    return got !== exp;
  endfunction

  task automatic bad(input string m);
    error_cnt++;
    $display("mismatch at %0t: %s", $time, m);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic aph(input logic [3:0] ty, input logic [12:0] a);
    ee2w_master_i.start();
    ee2w_master_i.wbyte({ty, pins, 1'b0}, ack);
    if (ne(ack, 8'h00)) bad("address byte refused");
    ee2w_master_i.wbyte({3'h0, a[12:8]}, ack);
    ee2w_master_i.wbyte(a[7:0], ack);
  endtask

  task automatic wr(input logic [3:0] ty, input logic [12:0] a, input logic [7:0] d[$]);
    aph(ty, a);
    foreach (d[i])
    begin
      ee2w_master_i.wbyte(d[i], ack);
      if (ne(ack, 8'h00)) bad("data byte refused");
    end
    ee2w_master_i.stop();
  endtask

  task automatic rd(input logic [3:0] ty, input logic [12:0] a, input logic [7:0] e[$]);
    aph(ty, a);
    ee2w_master_i.start();
    ee2w_master_i.wbyte({ty, pins, 1'b1}, ack);
    if (ne(ack, 8'h00)) bad("read address refused");
    foreach (e[i])
    begin
      ee2w_master_i.rbyte(rb, i == e.size() - 1);
      if (ne(rb, e[i])) bad("read data");
    end
    ee2w_master_i.stop();
  endtask

  // mn is the least busy length accepted, counted from the rise of busy
  task automatic prog(input logic exp, input int mn);
    int n;
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge mclk);
      n++;
    end
    if (ne(busy, exp)) bad("programming start");
    if (busy !== exp) summarize();
    n = 0;
    while (busy === 1'b1 && n < TW + 5)
    begin
      @(negedge mclk);
      n++;
    end
    if (busy === 1'b1)
    begin
      bad("programming did not end");
      summarize();
    end
    @(negedge mclk);
    if (exp && ne(blen >= mn && blen <= TW, 8'h01)) bad("programming length");
  endtask

  task automatic s_page();
    wr(DEV_TYPE, 13'h0123, '{8'h5A, 8'hC3});
    prog(1'b1, TW);
    ee2w_master_i.lo_ext = 150;
    rd(DEV_TYPE, 13'h0123, '{8'h5A, 8'hC3});
    ee2w_master_i.lo_ext = 0;
  endtask

  task automatic s_wrap();
    wr(DEV_TYPE, 13'h1FFE, '{8'h11, 8'h22, 8'h33});
    prog(1'b1, TW);
    rd(DEV_TYPE, 13'h1FE0, '{8'h33});
    rd(DEV_TYPE, 13'h1FFE, '{8'h11, 8'h22});
  endtask

  task automatic s_poll();
    wr(DEV_TYPE, 13'h0040, '{8'hA5});
    ee2w_master_i.start();
    ee2w_master_i.wbyte({DEV_TYPE, pins, 1'b0}, ack);
    if (ne(ack, 8'h01)) bad("acked while programming");
    ee2w_master_i.stop();
    prog(1'b1, TW);
    rd(DEV_TYPE, 13'h0040, '{8'hA5});
  endtask

  task automatic s_wp();
    @(negedge mclk);
    wp = 1'b1;
    wr(DEV_TYPE, 13'h0123, '{8'h00});
    prog(1'b0, 0);
    @(negedge mclk);
    wp = 1'b0;
    rd(DEV_TYPE, 13'h0123, '{8'h5A});
  endtask

  task automatic s_id();
    wr(ID_TYPE, 13'h0005, '{8'h77});
    prog(1'b1, TW);
    wr(ID_TYPE, 13'h0400, '{8'h00});
    prog(1'b1, TW);
    wr(ID_TYPE, 13'h0005, '{8'h11});
    prog(1'b0, 0);
    rd(ID_TYPE, 13'h0005, '{8'h77});
  endtask

  task automatic s_sel();
    logic [7:0] wrong[4];
    wrong = '{{DEV_TYPE, pins ^ 3'h1, 1'b0}, {DEV_TYPE, pins ^ 3'h2, 1'b0},
              {DEV_TYPE, pins ^ 3'h4, 1'b0}, {4'h5, pins, 1'b0}};
    foreach (wrong[i])
    begin
      ee2w_master_i.start();
      ee2w_master_i.wbyte(wrong[i], ack);
      if (ne(ack, 8'h01)) bad("foreign address acked");
      ee2w_master_i.stop();
    end
    @(negedge mclk);
    pins = 3'h2;
    repeat (4) @(negedge mclk);
    rd(DEV_TYPE, 13'h0040, '{8'hA5});
  endtask

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    srst = 1'b1;
    wp = 1'b0;
    pins = 3'h5;
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    s_page();
    s_wrap();
    s_poll();
    s_wp();
    s_id();
    s_sel();
    summarize();
  end

  initial
  begin
    #300000;
    bad("run did not finish");
    summarize();
  end
endmodule
